// ===== scpm_ctrl.sv
// Purpose: system clock select, fast oscillator control, halt power modes
// Assumes: fast/slow clocks already gated into pclk-rate tick strobes
// Notes: wake_up restores run mode; writable register fields are never touched by halt
// Behaviour
// - select 000-110 gives fast clock divided 1..64, 111 gives slow clock
// - fast keepalive bit 1 keeps fast oscillator running during halt
// - slow keepalive bit 0 keeps slow oscillator running during halt
// - clock switch completes after four current periods plus sync slack
// - fast frequency field 00/11 12MHz, 01 16MHz, 10 20MHz
// - delivered fast frequency changes only once stable flag is set
// - writing enable 1 while enable is 0, or with a new frequency, clears stable flag, then sets it when settled
// - fast oscillator enable bit 0 turns oscillator on, or off only while slow clock is selected
// - halt with both keepalives 0 enters sleep, system clock stops
// - halt with fast 0 slow 1 enters idle with slow clock only
// - halt with both keepalives 1 enters idle with both clocks
// - halt with fast 1 slow 0 enters idle with fast clock only
// - entering any halt mode sets power-down, clears timeout flag
// - entering any halt mode clears watchdog counter
// - halt modes keep memory, registers and port states unchanged
// - fast-to-slow switch waits for slow oscillator stable
// - slow-to-fast restart completion is shown by the stable flag
// - unimplemented register bits read 0 and ignore writes
// - in sleep the watchdog oscillator runs if watchdog enabled
`timescale 1ns/1ps
module scpm_ctrl
    import scpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core
    input wire logic halt_req,
    input wire logic wake_up,
    input wire logic wdt_clear_insn,
    input wire logic wdt_timeout,
    // oscillators (asynchronous status)
    input wire logic fast_osc_ready,
    input wire logic slow_osc_ready,
    input wire logic fast_tick,
    input wire logic slow_tick,
    // outputs
    output logic fast_osc_on,
    output logic [1:0] fast_freq_out,
    output logic [2:0] clk_src_sel,
    output logic sys_clk_en,
    output scpm_clk_gate_t gates,
    output logic wdt_cnt_clear,
    output logic [2:0] power_mode
);
    logic [7:0] scc_reg;
    logic [1:0] fsel_reg;
    logic fen_reg;
    logic fstable_reg;
    logic [1:0] fsel_live_reg;
    logic pdf_reg;
    logic to_reg;
    logic wdt_en_reg;
    logic [2:0] cks_live_reg;
    logic [CNT_W-1:0] sw_cnt_reg;
    logic [5:0] div_reg;
    logic sys_en_reg;
    scpm_mode_t mode_reg;
    scpm_sw_t sw_reg;
    logic fr_s1, fr_s2, sr_s1, sr_s2;
    logic wr, rd_hit;
    logic [2:0] cks_req;
    logic fast_stopped_req;

    function automatic logic [5:0] div_mask(input logic [2:0] c);
        div_mask = 6'((7'h01 << c) - 7'h01);
    endfunction

    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign cks_req = scc_reg[CKS_LSB +: 3];

    // synchronise oscillator ready levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_s1 <= 1'b0;
            fr_s2 <= 1'b0;
            sr_s1 <= 1'b0;
            sr_s2 <= 1'b0;
        end else begin
            fr_s1 <= fast_osc_ready;
            fr_s2 <= fr_s1;
            sr_s1 <= slow_osc_ready;
            sr_s2 <= sr_s1;
        end
    end

    // register writes; registers untouched by halt modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scc_reg <= SCC_RESET;
            fsel_reg <= FOSC_RESET[FSEL_LSB +: 2];
            fen_reg <= FOSC_RESET[FEN_BIT];
            wdt_en_reg <= 1'b1;
        end else if (wr) begin
            case (paddr[11:0])
                SYS_CLK_CTRL_ADDR: scc_reg <= pwdata[7:0] & SCC_WMASK;
                FAST_OSC_CTRL_ADDR: begin
                    fsel_reg <= pwdata[FSEL_LSB +: 2];
                    fen_reg <= pwdata[FEN_BIT];
                end
                WDT_CTRL_ADDR: wdt_en_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // stable flag: cleared on enable or freq change, set when settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fstable_reg <= 1'b0;
            fsel_live_reg <= FOSC_RESET[FSEL_LSB +: 2];
        end else if (wr && paddr[11:0] == FAST_OSC_CTRL_ADDR
                     && pwdata[FEN_BIT]
                     && (!fen_reg || pwdata[FSEL_LSB +: 2] != fsel_reg)) begin
            fstable_reg <= 1'b0;
        end else if (!fast_osc_on) begin
            fstable_reg <= 1'b0;
        end else if (fr_s2 && !fstable_reg) begin
            fstable_reg <= 1'b1;
            fsel_live_reg <= fsel_reg;
        end
    end

    // fast oscillator runs if enabled, or needed, unless halted without it
    assign fast_stopped_req = (mode_reg == PM_SLEEP)
        || (mode_reg == PM_IDLE_SLOW);
    // keepalive halts force it on even when enable bit is clear
    assign fast_osc_on = ((fen_reg || cks_live_reg != CKS_SLOW
                          || cks_req != CKS_SLOW) && !fast_stopped_req)
        || mode_reg == PM_IDLE_FAST || mode_reg == PM_IDLE_BOTH;
    assign fast_freq_out = fsel_live_reg;

    // clock switch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reg <= SW_IDLE;
            cks_live_reg <= SCC_RESET[CKS_LSB +: 3];
            sw_cnt_reg <= '0;
        end else begin
            case (sw_reg)
                SW_IDLE: if (cks_req != cks_live_reg) begin
                    sw_reg <= SW_WAIT_SRC;
                end
                SW_WAIT_SRC: begin
                    // target source must be stable first
                    if ((cks_req == CKS_SLOW && sr_s2)
                        || (cks_req != CKS_SLOW && fstable_reg)) begin
                        sw_reg <= SW_COUNT;
                        sw_cnt_reg <= '0;
                    end
                end
                SW_COUNT: begin
                    if (sys_en_reg) begin
                        sw_cnt_reg <= sw_cnt_reg + 1'b1;
                    end
                    if (sw_cnt_reg == CNT_W'(SWITCH_BASE_PERIODS
                                            + SWITCH_SYNC_STAGES)) begin
                        cks_live_reg <= cks_req;
                        sw_reg <= SW_IDLE;
                    end
                end
                default: sw_reg <= SW_IDLE;
            endcase
        end
    end
    assign clk_src_sel = cks_live_reg;

    // system clock enable from divider of the fast tick, or the slow tick undivided
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            sys_en_reg <= 1'b0;
        end else begin
            sys_en_reg <= 1'b0;
            if (mode_reg != PM_RUN) begin
                div_reg <= '0;
            end else if (cks_live_reg == CKS_SLOW) begin
                sys_en_reg <= slow_tick;
            end else if (fast_tick && fstable_reg) begin
                if ((div_reg & div_mask(cks_live_reg)) ==
                    div_mask(cks_live_reg)) begin
                    div_reg <= '0;
                    sys_en_reg <= 1'b1;
                end else begin
                    div_reg <= div_reg + 6'h01;
                end
            end
        end
    end
    assign sys_clk_en = sys_en_reg;

    // power mode on halt strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= PM_RUN;
        end else if (mode_reg == PM_RUN && halt_req) begin
            case (scc_reg[FAST_KEEP_BIT:SLOW_KEEP_BIT])
                2'b00: mode_reg <= PM_SLEEP;
                2'b01: mode_reg <= PM_IDLE_SLOW;
                2'b11: mode_reg <= PM_IDLE_BOTH;
                2'b10: mode_reg <= PM_IDLE_FAST;
                default: mode_reg <= PM_SLEEP;
            endcase
        end else if (mode_reg != PM_RUN && wake_up) begin
            mode_reg <= PM_RUN;
        end
    end
    assign power_mode = mode_reg;

    // status flags; timeout set wins over halt clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdf_reg <= 1'b0;
            to_reg <= 1'b0;
        end else begin
            if (mode_reg == PM_RUN && halt_req) begin
                pdf_reg <= 1'b1;
            end else if (wdt_clear_insn) begin
                pdf_reg <= 1'b0;
            end
            if (wdt_timeout) begin
                to_reg <= 1'b1;
            end else if ((mode_reg == PM_RUN && halt_req) || wdt_clear_insn)
            begin
                to_reg <= 1'b0;
            end
        end
    end

    // watchdog counter clear pulse on halt entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_clear <= 1'b0;
        end else begin
            wdt_cnt_clear <= (mode_reg == PM_RUN && halt_req)
                || wdt_clear_insn;
        end
    end

    // clock gates per mode
    always_comb begin
        gates.fast_run = fast_osc_on;
        gates.cpu_clk_en = (mode_reg == PM_RUN);
        gates.slow_run = (mode_reg == PM_RUN) || scc_reg[SLOW_KEEP_BIT];
        gates.wdt_osc_run = gates.slow_run || wdt_en_reg;
    end

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr[11:0])
            SYS_CLK_CTRL_ADDR: prdata[7:0] = scc_reg;
            FAST_OSC_CTRL_ADDR: prdata[3:0] = {fsel_reg, fstable_reg,
                                               fen_reg};
            PWR_STATUS_ADDR: prdata[6:0] = {to_reg, pdf_reg, mode_reg,
                                            cks_live_reg != cks_req,
                                            sr_s2};
            WDT_CTRL_ADDR: prdata[0] = wdt_en_reg;
            default: rd_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !rd_hit;
endmodule

// ===== scpm_pkg.sv
// Purpose: constants and types for the system clock / power mode block
// Assumes: apb slave, 32-bit data, one word per register
// Notes: oscillators modelled as enable/stable handshakes
package scpm_pkg;
    // register byte addresses
    localparam logic [11:0] SYS_CLK_CTRL_ADDR = 12'h000;
    localparam logic [11:0] FAST_OSC_CTRL_ADDR = 12'h004;
    localparam logic [11:0] PWR_STATUS_ADDR = 12'h008;
    localparam logic [11:0] WDT_CTRL_ADDR = 12'h00C;
    // system clock control fields
    localparam int CKS_LSB = 5;
    localparam int FAST_KEEP_BIT = 1;
    localparam int SLOW_KEEP_BIT = 0;
    localparam logic [7:0] SCC_RESET = 8'h20;
    localparam logic [7:0] SCC_WMASK = 8'hE3;
    // fast oscillator control fields
    localparam int FSEL_LSB = 2;
    localparam int FSTABLE_BIT = 1;
    localparam int FEN_BIT = 0;
    localparam logic [3:0] FOSC_RESET = 4'h1;
    localparam logic [2:0] CKS_SLOW = 3'b111;
    // switching delay: four current periods plus sync slack
    localparam int SWITCH_BASE_PERIODS = 4;
    localparam int SWITCH_SYNC_STAGES = 2;
    localparam int CNT_W = 8;
    // power mode encoding
    typedef enum logic [2:0] {
        PM_RUN = 3'b000,
        PM_SLEEP = 3'b001,
        PM_IDLE_SLOW = 3'b011,
        PM_IDLE_BOTH = 3'b010,
        PM_IDLE_FAST = 3'b110
    } scpm_mode_t;
    // clock switch sequencer
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT_SRC = 2'b01,
        SW_COUNT = 2'b11
    } scpm_sw_t;
    typedef struct packed {
        logic fast_run;
        logic slow_run;
        logic cpu_clk_en;
        logic wdt_osc_run;
    } scpm_clk_gate_t;
endpackage

// ===== scpm_osc_model.sv
// Purpose: oscillator stand-in for scpm_ctrl
// Assumes: ticks are one pclk wide
// Notes: fast start-up cut to a few cycles
`timescale 1ns/1ps
module scpm_osc_model #(
    parameter int FAST_START = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fast_osc_on,
    output logic fast_osc_ready,
    output logic slow_osc_ready,
    output logic fast_tick,
    output logic slow_tick
);
    logic [7:0] f_cnt;
    logic [2:0] t_cnt;
    logic s_up;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_cnt <= 8'h00;
            t_cnt <= 3'h0;
            s_up <= 1'b0;
        end else begin
            // restart from zero whenever switched off
            if (!fast_osc_on) f_cnt <= 8'h00;
            else if (f_cnt < 8'(FAST_START)) f_cnt <= f_cnt + 8'h01;
            t_cnt <= t_cnt + 3'h1;
            if (t_cnt == 3'h7) s_up <= 1'b1;
        end
    end
    assign fast_osc_ready = fast_osc_on && f_cnt == 8'(FAST_START);
    assign slow_osc_ready = s_up;
    assign fast_tick = fast_osc_ready && t_cnt[0];
    assign slow_tick = s_up && t_cnt == 3'h7;
endmodule

// ===== scpm_ctrl_checker.sv
// Purpose: port assertions for scpm_ctrl
// Assumes: one pclk domain
// Notes: register contents are not visible here
`timescale 1ns/1ps
module scpm_ctrl_checker
    import scpm_pkg::*;
(
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr, halt_req, wake_up, wdt_cnt_clear,
    input wire scpm_clk_gate_t gates,
    input wire logic [2:0] power_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence halt_taken;
        halt_req && power_mode == PM_RUN;
    endsequence
    chk_unmapped_zero: assert property (psel && penable && !pwrite &&
        pslverr |-> prdata == 32'h0000_0000) else $error("bad read data");
    chk_halt_enter: assert property (halt_taken |=>
        power_mode != PM_RUN) else $error("halt ignored");
    chk_halt_wdt: assert property (halt_taken |=>
        wdt_cnt_clear) else $error("no watchdog clear");
    chk_wake_run: assert property (wake_up && power_mode != PM_RUN
        |=> power_mode == PM_RUN) else $error("no wake");
    chk_sleep_gates: assert property (power_mode == PM_SLEEP |->
        !(gates.fast_run || gates.slow_run || gates.cpu_clk_en))
        else $error("clock live in sleep");
    chk_idle_slow: assert property (power_mode == PM_IDLE_SLOW |->
        !gates.fast_run && gates.slow_run) else $error("idle slow gates");
    chk_idle_fast: assert property (power_mode == PM_IDLE_FAST |->
        gates.fast_run && !gates.slow_run) else $error("idle fast gates");
    chk_mode_hold: assert property (power_mode != PM_RUN && !wake_up
        |=> power_mode == $past(power_mode)) else $error("mode drift");
endmodule
bind scpm_ctrl scpm_ctrl_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pslverr(pslverr), .halt_req(halt_req), .wake_up(wake_up),
    .wdt_cnt_clear(wdt_cnt_clear), .gates(gates), .power_mode(power_mode));

// ===== scpm_ctrl_tb.sv
// Purpose: directed apb test of scpm_ctrl
// Assumes: apb usable in every power mode
// Notes: data sampled at the taking edge, before its register updates
`timescale 1ns/1ps
module scpm_ctrl_tb;
    import scpm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic halt_req = 0, wake_up = 0, wdt_clr = 0, wdt_to = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    logic f_rdy, s_rdy, f_tk, s_tk, f_on, pready, pslverr, s_en, wclr;
    logic [1:0] f_fr;
    logic [2:0] sel, pm;
    scpm_clk_gate_t gates;
    scpm_mode_t mode_of [4] = '{PM_SLEEP, PM_IDLE_SLOW, PM_IDLE_FAST,
        PM_IDLE_BOTH};
    int bad_count = 0, comparisons = 0, n;
    always #10 pclk = ~pclk;
    scpm_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_req(halt_req), .wake_up(wake_up), .wdt_clear_insn(wdt_clr),
        .wdt_timeout(wdt_to), .fast_osc_ready(f_rdy), .slow_osc_ready(s_rdy),
        .fast_tick(f_tk), .slow_tick(s_tk), .fast_osc_on(f_on),
        .fast_freq_out(f_fr), .clk_src_sel(sel), .sys_clk_en(s_en),
        .gates(gates), .wdt_cnt_clear(wclr), .power_mode(pm));
    scpm_osc_model osc (.pclk(pclk), .presetn(presetn), .fast_osc_on(f_on),
        .fast_osc_ready(f_rdy), .slow_osc_ready(s_rdy), .fast_tick(f_tk),
        .slow_tick(s_tk));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            rd = prdata;
            err = pslverr;
            rdy = pready;
            n++;
        end while (rdy !== 1'b1 && n < 20);
        psel <= 0;
        penable <= 0;
        chk(32'(n < 20), 1);
        if (n >= 20) wrap_up;
    endtask
    // bounded wait on the live select, then compare
    task sel_is(input logic [2:0] c);
        n = 0;
        while (sel !== c && n < 4000) begin
            @(negedge pclk);
            n++;
        end
        chk(32'(sel), 32'(c));
        if (n >= 4000) wrap_up;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, SYS_CLK_CTRL_ADDR, 0);
        chk(rd, 32'h0000_0020);
        for (int c = 0; c < 8; c++) begin
            apb(1, SYS_CLK_CTRL_ADDR, 32'(c << 5) | 32'h0000_001F);
            @(negedge pclk);
            chk(32'(sel), (c == 0) ? 32'h1 : 32'(c - 1));
            sel_is(3'(c));
            apb(0, SYS_CLK_CTRL_ADDR, 0);
            chk(rd, 32'(c << 5) | 32'h0000_0003);
        end
        apb(1, FAST_OSC_CTRL_ADDR, 32'h0000_0000);
        @(negedge pclk);
        chk(32'(f_on), 0);
        apb(1, FAST_OSC_CTRL_ADDR, 32'hFFFF_FFF5);
        chk(32'(err), 0);
        @(negedge pclk);
        chk(32'(f_on), 1);
        apb(0, FAST_OSC_CTRL_ADDR, 0);
        chk(rd, 32'h0000_0005);
        chk(32'(f_fr), 0);
        for (int m = 0; m < 50 && rd[1] !== 1'b1; m++)
            apb(0, FAST_OSC_CTRL_ADDR, 0);
        chk(rd, 32'h0000_0007);
        @(negedge pclk);
        chk(32'(f_fr), 1);
        apb(1, SYS_CLK_CTRL_ADDR, 0);
        sel_is(3'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1, SYS_CLK_CTRL_ADDR, 32'(k));
            wdt_to <= 1;
            @(posedge pclk);
            wdt_to <= 0;
            halt_req <= 1;
            @(posedge pclk);
            halt_req <= 0;
            @(negedge pclk);
            chk(32'(pm), 32'(mode_of[k]));
            if (k == 0) chk(32'(gates.wdt_osc_run), 1);
            apb(0, PWR_STATUS_ADDR, 0);
            chk(32'(rd[6:5]), 1);
            apb(0, SYS_CLK_CTRL_ADDR, 0);
            chk(rd, 32'(k));
            wake_up <= 1;
            @(posedge pclk);
            wake_up <= 0;
            @(negedge pclk);
            chk(32'(pm), 32'(PM_RUN));
        end
        apb(1, 12'h010, 32'hFFFF_FFFF);
        chk(32'(err), 1);
        apb(0, 12'h010, 0);
        chk(rd, 0);
        wdt_clr <= 1;
        @(posedge pclk);
        wdt_clr <= 0;
        apb(0, PWR_STATUS_ADDR, 0);
        chk(32'(rd[6:5]), 0);
        wrap_up;
    end
endmodule
